// [rtl/amp_status_pkg.sv]
// constants for the amplifier status bank: offsets, fields, resets
// assumes a byte-wide register pointer driven by the control port
package amp_status_pkg;

  // register offsets
  localparam logic [7:0] LOAD_DIAG_RESULT_CH3_CH4_OFS = 8'h0D;
  localparam logic [7:0] LINE_OUTPUT_DETECT_OFS       = 8'h0E;
  localparam logic [7:0] CHANNEL_STATE_REPORT_OFS     = 8'h0F;
  localparam logic [7:0] CHANNEL_FAULT_FLAGS_OFS      = 8'h10;
  localparam logic [7:0] GLOBAL_CLOCK_SUPPLY_OFS      = 8'h11;
  localparam logic [7:0] OVERTEMP_SHUTDOWN_OFS        = 8'h12;

  // reset values and the value read at unmapped offsets
  localparam logic [7:0] LOAD_DIAG_RESET     = 8'h00;
  localparam logic [7:0] LINE_DETECT_RESET   = 8'h00;
  localparam logic [7:0] CHANNEL_STATE_RESET = 8'h55;
  localparam logic [7:0] CHANNEL_FAULT_RESET = 8'h00;
  localparam logic [7:0] GLOBAL_FAULT_RESET  = 8'h00;
  localparam logic [7:0] OVERTEMP_RESET      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;

  // field positions: load diagnostic nibble, ch3 high, ch4 low
  localparam int LOAD_DIAG_CH3_LSB  = 4;
  localparam int LOAD_DIAG_CH4_LSB  = 0;
  localparam int GROUND_SHORT_POS   = 3;
  localparam int SUPPLY_SHORT_POS   = 2;
  localparam int OPEN_LOAD_POS      = 1;
  localparam int SHORTED_LOAD_POS   = 0;
  // channel fault register
  localparam int OVERCURRENT_LSB    = 4;
  localparam int DC_FAULT_LSB       = 0;
  // global clock and supply register
  localparam int INVALID_CLOCK_POS  = 4;
  localparam int STAGE_OV_POS       = 3;
  localparam int BATTERY_OV_POS     = 2;
  localparam int STAGE_UV_POS       = 1;
  localparam int BATTERY_UV_POS     = 0;
  // overtemperature register
  localparam int OVERTEMP_SHUTDOWN_FLAG_GLOBAL_POS    = 4;
  localparam int OVERTEMP_SHUTDOWN_FLAG_CHANNEL_LSB   = 0;
  // width of each per-channel state field
  localparam int STATE_FIELD_W      = 2;

  // channel state codes
  typedef enum logic [1:0] {
    CH_PLAY     = 2'b00,
    CH_HIZ      = 2'b01,
    CH_MUTE     = 2'b10,
    CH_DC_DIAG  = 2'b11
  } ch_state_t;

  // control port sequencer states
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_ADDR      = 4'b0001,
    ST_ADDR_ACK  = 4'b0010,
    ST_PTR       = 4'b0011,
    ST_PTR_ACK   = 4'b0100,
    ST_WRITE     = 4'b0101,
    ST_WRITE_ACK = 4'b0110,
    ST_READ      = 4'b0111,
    ST_READ_ACK  = 4'b1000
  } port_state_t;

endpackage : amp_status_pkg

// [rtl/amp_diag_fault_status_bank.sv]
// read-only status bank of a four-channel amplifier behind a two-wire control port
// assumes I_SCL and I_SDA are already synchronous to I_CLK and glitch free;
// the pad combines O_SDA and O_SDA_OE into an open-drain wire
//
// Functional notes
// - load diagnostic byte at 0x0D, ch3 flags high nibble, ch4 low nibble.
// - ground-short flag is 1 when output was found shorted to ground.
// - supply-short flag is 1 when output was found shorted to supply.
// - open-load flag is 1 when no load was found on the channel.
// - shorted-load flag is 1 when the channel load was found shorted.
// - line detect byte at 0x0E, bits 3..0 channels 1..4, upper zero.
// - line detect bit is 1 when a line-level load was detected.
// - channel state byte at 0x0F, resets 0x55, two bits per channel.
// - state code 00 play, 01 high impedance, 10 muted, 11 diagnostics.
// - channel fault byte at 0x10, overcurrent high nibble, DC low nibble.
// - overcurrent flag is 1 when overcurrent was detected on channel.
// - DC fault flag is 1 when a DC offset fault was detected.
// - global fault byte at 0x11, clock and supply bits 4..0, rest zero.
// - invalid clock flag is 1 when incoming audio clocks are faulty.
// - overvoltage flags are 1 when the matching supply overvoltage is seen.
// - undervoltage flags are 1 when the matching supply undervoltage is seen.
// - overtemperature byte at 0x12, bit 4 global, bits 3..0 channels.
// - each shutdown flag is 1 when its overtemperature shutdown happened.
`timescale 1ns/100ps

module amp_diag_fault_status_bank
  import amp_status_pkg::*;
#(
  // bus address of the device; value is arbitrary
  parameter logic [6:0] DEVICE_ADDR = 7'h10
) (
  input  wire logic       I_CLK,
  input  wire logic       I_RESET,
  input  wire logic       I_SCL,
  input  wire logic       I_SDA,
  output logic            O_SDA,
  output logic            O_SDA_OE,
  input  wire logic [1:0] I_GROUND_SHORT_FLAG,
  input  wire logic [1:0] I_SUPPLY_SHORT_FLAG,
  input  wire logic [1:0] I_OPEN_LOAD_FLAG,
  input  wire logic [1:0] I_SHORTED_LOAD_FLAG,
  input  wire logic [3:0] I_LINE_OUTPUT_DETECT_BIT,
  input  wire logic [3:0] I_CH_HIZ,
  input  wire logic [3:0] I_CH_MUTED,
  input  wire logic [3:0] I_CH_DC_DIAG,
  input  wire logic [3:0] I_OVERCURRENT_FLAG,
  input  wire logic [3:0] I_DC_FAULT_FLAG,
  input  wire logic       I_INVALID_CLOCK,
  input  wire logic       I_STAGE_SUPPLY_OVERVOLTAGE_FLAG,
  input  wire logic       I_BATTERY_OVERVOLTAGE_FLAG,
  input  wire logic       I_STAGE_SUPPLY_UNDERVOLTAGE_FLAG,
  input  wire logic       I_BATTERY_UNDERVOLTAGE_FLAG,
  input  wire logic       I_OVERTEMP_SHUTDOWN_GLOBAL,
  input  wire logic [3:0] I_OVERTEMP_SHUTDOWN_FLAG
);

  typedef struct packed {
    port_state_t state;
    logic        scl_q;
    logic        sda_q;
    logic [2:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        rw;
    logic        half;
    logic        sda_oe;
    logic [7:0]  load_diag;
    logic [7:0]  line_det;
    logic [7:0]  ch_state;
    logic [7:0]  ch_fault;
    logic [7:0]  glob_fault;
    logic [7:0]  overtemp;
  } bank_st_t;

  localparam bank_st_t RESET_ST = '{
    state:      ST_IDLE,
    scl_q:      1'b1,
    sda_q:      1'b1,
    bitcnt:     3'h0,
    shreg:      8'h00,
    ptr:        8'h00,
    rw:         1'b0,
    half:       1'b0,
    sda_oe:     1'b0,
    load_diag:  LOAD_DIAG_RESET,
    line_det:   LINE_DETECT_RESET,
    ch_state:   CHANNEL_STATE_RESET,
    ch_fault:   CHANNEL_FAULT_RESET,
    glob_fault: GLOBAL_FAULT_RESET,
    overtemp:   OVERTEMP_RESET
  };

  bank_st_t   st;
  bank_st_t   next_st;
  logic [7:0] state_code;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;

  // state encoding per channel
  // diagnostics outrank high impedance, which outranks mute
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_state
      // one driver per field slice, so no two processes share state_code
      assign state_code[(3-ch)*STATE_FIELD_W +: STATE_FIELD_W] =
        I_CH_DC_DIAG[3-ch] ? CH_DC_DIAG :
        I_CH_HIZ[3-ch]     ? CH_HIZ     :
        I_CH_MUTED[3-ch]   ? CH_MUTE    :
                             CH_PLAY;
    end
  endgenerate

  function automatic logic [7:0] read_mux(input logic [7:0] ofs, input bank_st_t s);
    logic [7:0] val;
    val = UNMAPPED_READ;
    case (ofs)
      LOAD_DIAG_RESULT_CH3_CH4_OFS: val = s.load_diag;
      LINE_OUTPUT_DETECT_OFS:       val = s.line_det;
      CHANNEL_STATE_REPORT_OFS:     val = s.ch_state;
      CHANNEL_FAULT_FLAGS_OFS:      val = s.ch_fault;
      GLOBAL_CLOCK_SUPPLY_OFS:      val = s.glob_fault;
      OVERTEMP_SHUTDOWN_OFS:        val = s.overtemp;
      default:                      val = UNMAPPED_READ;
    endcase
    return val;
  endfunction : read_mux

  assign scl_rise   = I_SCL & ~st.scl_q;
  assign scl_fall   = ~I_SCL & st.scl_q;
  assign start_cond = st.scl_q & I_SCL & st.sda_q & ~I_SDA;
  assign stop_cond  = st.scl_q & I_SCL & ~st.sda_q & I_SDA;
  assign rx_byte    = {st.shreg[6:0], I_SDA};
  assign rd_byte    = read_mux(st.ptr, st);

  always_comb begin
    next_st       = st;
    next_st.scl_q = I_SCL;
    next_st.sda_q = I_SDA;

    // status mirrors follow the analog detectors every cycle
    // load diagnostic layout
    next_st.load_diag[LOAD_DIAG_CH3_LSB + GROUND_SHORT_POS] = I_GROUND_SHORT_FLAG[1];
    next_st.load_diag[LOAD_DIAG_CH4_LSB + GROUND_SHORT_POS] = I_GROUND_SHORT_FLAG[0];
    next_st.load_diag[LOAD_DIAG_CH3_LSB + SUPPLY_SHORT_POS] = I_SUPPLY_SHORT_FLAG[1];
    next_st.load_diag[LOAD_DIAG_CH4_LSB + SUPPLY_SHORT_POS] = I_SUPPLY_SHORT_FLAG[0];
    next_st.load_diag[LOAD_DIAG_CH3_LSB + OPEN_LOAD_POS]    = I_OPEN_LOAD_FLAG[1];
    next_st.load_diag[LOAD_DIAG_CH4_LSB + OPEN_LOAD_POS]    = I_OPEN_LOAD_FLAG[0];
    next_st.load_diag[LOAD_DIAG_CH3_LSB + SHORTED_LOAD_POS] = I_SHORTED_LOAD_FLAG[1];
    next_st.load_diag[LOAD_DIAG_CH4_LSB + SHORTED_LOAD_POS] = I_SHORTED_LOAD_FLAG[0];
    next_st.line_det = {4'h0, I_LINE_OUTPUT_DETECT_BIT};
    next_st.ch_state = state_code;
    next_st.ch_fault = 8'h00;
    next_st.ch_fault[OVERCURRENT_LSB +: 4] = I_OVERCURRENT_FLAG;
    next_st.ch_fault[DC_FAULT_LSB +: 4]    = I_DC_FAULT_FLAG;
    // global clock and supply faults, reserved bits zero
    next_st.glob_fault = 8'h00;
    next_st.glob_fault[INVALID_CLOCK_POS] = I_INVALID_CLOCK;
    next_st.glob_fault[STAGE_OV_POS]      = I_STAGE_SUPPLY_OVERVOLTAGE_FLAG;
    next_st.glob_fault[BATTERY_OV_POS]    = I_BATTERY_OVERVOLTAGE_FLAG;
    next_st.glob_fault[STAGE_UV_POS]      = I_STAGE_SUPPLY_UNDERVOLTAGE_FLAG;
    next_st.glob_fault[BATTERY_UV_POS]    = I_BATTERY_UNDERVOLTAGE_FLAG;
    next_st.overtemp = 8'h00;
    next_st.overtemp[OVERTEMP_SHUTDOWN_FLAG_GLOBAL_POS]       = I_OVERTEMP_SHUTDOWN_GLOBAL;
    next_st.overtemp[OVERTEMP_SHUTDOWN_FLAG_CHANNEL_LSB +: 4] = I_OVERTEMP_SHUTDOWN_FLAG;

    if (start_cond) begin
      // repeated start keeps the pointer for a combined read
      next_st.state  = ST_ADDR;
      next_st.bitcnt = 3'h0;
      next_st.half   = 1'b0;
      next_st.sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_st.state  = ST_IDLE;
      next_st.half   = 1'b0;
      next_st.sda_oe = 1'b0;
    end else begin
      case (st.state)
        ST_IDLE: begin
          next_st.sda_oe = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WRITE: begin
          if (scl_rise) begin
            next_st.shreg  = rx_byte;
            next_st.bitcnt = st.bitcnt + 3'h1;
            if (st.bitcnt == 3'h7) begin
              if (st.state == ST_ADDR) begin
                // other addresses are not ours: stay off the wire
                next_st.state = (rx_byte[7:1] == DEVICE_ADDR) ? ST_ADDR_ACK : ST_IDLE;
                next_st.rw    = rx_byte[0];
              end else if (st.state == ST_PTR) begin
                next_st.ptr   = rx_byte;
                next_st.state = ST_PTR_ACK;
              end else begin
                next_st.state = ST_WRITE_ACK;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WRITE_ACK: begin
          if (scl_fall && !st.half) begin
            next_st.sda_oe = 1'b1;
            next_st.half   = 1'b1;
          end else if (scl_fall) begin
            next_st.half   = 1'b0;
            next_st.bitcnt = 3'h0;
            next_st.sda_oe = 1'b0;
            if (st.state == ST_ADDR_ACK && st.rw) begin
              next_st.state  = ST_READ;
              next_st.shreg  = rd_byte;
              next_st.sda_oe = ~rd_byte[7];
            end else if (st.state == ST_ADDR_ACK) begin
              next_st.state = ST_PTR;
            end else if (st.state == ST_PTR_ACK) begin
              next_st.state = ST_WRITE;
            end else begin
              // data byte dropped, pointer moves on
              next_st.state = ST_WRITE;
              next_st.ptr   = st.ptr + 8'h01;
            end
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (st.bitcnt == 3'h7) begin
              next_st.sda_oe = 1'b0;
              next_st.state  = ST_READ_ACK;
              next_st.ptr    = st.ptr + 8'h01;
            end else begin
              next_st.bitcnt = st.bitcnt + 3'h1;
              next_st.shreg  = {st.shreg[6:0], 1'b0};
              next_st.sda_oe = ~st.shreg[6];
            end
          end
        end
        ST_READ_ACK: begin
          if (scl_rise) begin
            // not-acknowledge ends the read burst
            next_st.state = I_SDA ? ST_IDLE : ST_READ_ACK;
            next_st.half  = ~I_SDA;
          end else if (scl_fall && st.half) begin
            // pointer already advanced, so the current byte is the next one
            next_st.half   = 1'b0;
            next_st.bitcnt = 3'h0;
            next_st.state  = ST_READ;
            next_st.shreg  = rd_byte;
            next_st.sda_oe = ~rd_byte[7];
          end
        end
        default: begin
          next_st.state  = ST_IDLE;
          next_st.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  // open drain: only ever pull low
  assign O_SDA    = 1'b0;
  assign O_SDA_OE = st.sda_oe;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  a_diag_ch3_flags: assert property (
    ##1 st.load_diag[7:4] == $past({I_GROUND_SHORT_FLAG[1], I_SUPPLY_SHORT_FLAG[1],
                                I_OPEN_LOAD_FLAG[1], I_SHORTED_LOAD_FLAG[1]}))
    else $error("ch3 load diagnostic flags wrong");

  a_diag_ch4_flags: assert property (
    ##1 st.load_diag[3:0] == $past({I_GROUND_SHORT_FLAG[0], I_SUPPLY_SHORT_FLAG[0],
                                I_OPEN_LOAD_FLAG[0], I_SHORTED_LOAD_FLAG[0]}))
    else $error("ch4 load diagnostic flags wrong");

  a_reserved_zero: assert property (
    st.line_det[7:4] == 4'h0 && st.glob_fault[7:5] == 3'h0 && st.overtemp[7:5] == 3'h0)
    else $error("reserved bits not zero");

  a_state_diag_code: assert property (
    I_CH_DC_DIAG[3] |=> st.ch_state[7:6] == CH_DC_DIAG)
    else $error("ch1 diagnostic state code wrong");

  a_state_play_code: assert property (
    (I_CH_DC_DIAG[0] == 1'b0 && I_CH_HIZ[0] == 1'b0 && I_CH_MUTED[0] == 1'b0)
      |=> st.ch_state[1:0] == CH_PLAY)
    else $error("ch4 play state code wrong");

  a_fault_layout: assert property (
    ##1 st.ch_fault == {$past(I_OVERCURRENT_FLAG), $past(I_DC_FAULT_FLAG)})
    else $error("channel fault layout wrong");

  a_clock_flag: assert property (
    $rose(I_INVALID_CLOCK) |=> st.glob_fault[INVALID_CLOCK_POS])
    else $error("invalid clock flag not set");

  a_supply_flags: assert property (
    ##1 st.glob_fault[3:0] == $past({I_STAGE_SUPPLY_OVERVOLTAGE_FLAG,
      I_BATTERY_OVERVOLTAGE_FLAG, I_STAGE_SUPPLY_UNDERVOLTAGE_FLAG,
      I_BATTERY_UNDERVOLTAGE_FLAG}))
    else $error("supply fault flags wrong");

  a_overtemp_flags: assert property (
    ##1 st.overtemp[4:0] == {$past(I_OVERTEMP_SHUTDOWN_GLOBAL), $past(I_OVERTEMP_SHUTDOWN_FLAG)})
    else $error("shutdown flags wrong");

  a_write_no_effect: assert property (
    (st.state == ST_WRITE && scl_rise && st.bitcnt == 3'h7)
      |=> st.state == ST_WRITE_ACK && st.ptr == $past(st.ptr))
    else $error("write byte disturbed the pointer");

  a_read_load_mux: assert property (
    (st.state == ST_ADDR_ACK && st.rw && scl_fall && st.half)
      |=> st.state == ST_READ && st.shreg == $past(rd_byte) && st.bitcnt == 3'h0)
    else $error("read byte not loaded from pointer");

  a_drive_only_owned: assert property (
    O_SDA_OE |-> (st.state inside {ST_ADDR_ACK, ST_PTR_ACK, ST_WRITE_ACK, ST_READ}))
    else $error("data line driven outside ack or read");

  a_nack_ends_read: assert property (
    (st.state == ST_READ_ACK && scl_rise && I_SDA && !start_cond && !stop_cond)
      |=> st.state == ST_IDLE ##1 !O_SDA_OE)
    else $error("nack did not end the read");

endmodule : amp_diag_fault_status_bank

// [verification/status_host_model.sv]
// host side of the two-wire control port: start, stop, byte transfers
// assumes an external pull-up, so a released data wire reads high
`timescale 1ns/100ps

module status_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h10
) (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull
);
  logic [7:0] rx [0:7];
  logic       acks;

  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
    acks       = 1'b1;
  end

  // four clocks per phase, above the three clock minimum
  task automatic wt();
    repeat (4) @(posedge i_clk);
    #1;
  endtask : wt

  // works as start and as repeated start
  task automatic begin_xfer();
    o_sda_pull = 1'b0;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_pull = 1'b1;
    wt();
    o_scl = 1'b0;
    wt();
  endtask : begin_xfer

  task automatic stop_xfer();
    o_sda_pull = 1'b1;
    wt();
    o_scl = 1'b1;
    wt();
    o_sda_pull = 1'b0;
    wt();
  endtask : stop_xfer

  // data only changes a full phase after the falling edge
  task automatic bit_xfer(input logic b, output logic s);
    o_sda_pull = ~b;
    wt();
    o_scl = 1'b1;
    wt();
    s = i_sda;
    o_scl = 1'b0;
    wt();
  endtask : bit_xfer

  task automatic byte_xfer(input logic [7:0] d, input logic ack_bit,
                           output logic [7:0] r, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r[i]);
    end
    bit_xfer(ack_bit, s);
    a = ~s;
  endtask : byte_xfer

  task automatic send(input logic [7:0] d);
    logic [7:0] r;
    logic       a;
    byte_xfer(d, 1'b1, r, a);
    acks = acks & a;
  endtask : send

  // reads n bytes from the current pointer, last byte not acknowledged
  task automatic read_cur(input int n);
    logic a;
    begin_xfer();
    send({DEV_ADDR, 1'b1});
    for (int k = 0; k < n; k++) begin
      byte_xfer(8'hFF, (k == n - 1), rx[k], a);
    end
    stop_xfer();
  endtask : read_cur

  task automatic read_burst(input logic [7:0] ptr, input int n);
    acks = 1'b1;
    begin_xfer();
    send({DEV_ADDR, 1'b0});
    send(ptr);
    read_cur(n);
  endtask : read_burst

  task automatic write_two(input logic [7:0] ptr, input logic [7:0] d0,
                           input logic [7:0] d1);
    acks = 1'b1;
    begin_xfer();
    send({DEV_ADDR, 1'b0});
    send(ptr);
    send(d0);
    send(d1);
    stop_xfer();
  endtask : write_two

  task automatic probe(input logic [6:0] addr);
    acks = 1'b1;
    begin_xfer();
    send({addr, 1'b0});
    stop_xfer();
  endtask : probe
endmodule : status_host_model

// [verification/amp_diag_fault_status_bank_test.sv]
// self-checking bench for the amplifier status bank over its control port
// assumes the host model above and a pull-up on the shared data wire
`timescale 1ns/100ps

module amp_diag_fault_status_bank_test;
  logic       clk, rst, scl, pull, sda_out, sda_oe;
  wire  logic sda;
  logic [1:0] gs, ss, ol, sl;
  logic [3:0] line, hiz, mute, diag, oc, dc, otf;
  logic       inv_clk, sov, bov, suv, buv, otg;
  logic [7:0] v [0:5];
  logic [7:0] pat [0:10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20,
                             8'h40, 8'h80, 8'hFF, 8'hA5, 8'h1B};
  logic [7:0] msk [0:5] = '{8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h1F, 8'h1F};
  int         n_errors, check_count, cycles;

  assign sda = ~(pull | (sda_oe & ~sda_out));

  amp_diag_fault_status_bank dut_u (
    .I_CLK(clk), .I_RESET(rst), .I_SCL(scl), .I_SDA(sda), .O_SDA(sda_out),
    .O_SDA_OE(sda_oe), .I_GROUND_SHORT_FLAG(gs), .I_SUPPLY_SHORT_FLAG(ss),
    .I_OPEN_LOAD_FLAG(ol), .I_SHORTED_LOAD_FLAG(sl), .I_LINE_OUTPUT_DETECT_BIT(line),
    .I_CH_HIZ(hiz), .I_CH_MUTED(mute), .I_CH_DC_DIAG(diag), .I_OVERCURRENT_FLAG(oc),
    .I_DC_FAULT_FLAG(dc), .I_INVALID_CLOCK(inv_clk),
    .I_STAGE_SUPPLY_OVERVOLTAGE_FLAG(sov), .I_BATTERY_OVERVOLTAGE_FLAG(bov),
    .I_STAGE_SUPPLY_UNDERVOLTAGE_FLAG(suv), .I_BATTERY_UNDERVOLTAGE_FLAG(buv),
    .I_OVERTEMP_SHUTDOWN_GLOBAL(otg), .I_OVERTEMP_SHUTDOWN_FLAG(otf)
  );

  status_host_model host_u (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // drives the status inputs so that each register should read v[] masked by msk[]
  task automatic apply();
    gs = {v[0][7], v[0][3]};
    ss = {v[0][6], v[0][2]};
    ol = {v[0][5], v[0][1]};
    sl = {v[0][4], v[0][0]};
    line = v[1][3:0];
    for (int k = 0; k < 4; k++) begin
      diag[3-k] = (v[2][7-2*k -: 2] == 2'b11);
      hiz[3-k]  = (v[2][7-2*k -: 2] == 2'b01);
      mute[3-k] = (v[2][7-2*k -: 2] == 2'b10);
    end
    {oc, dc} = v[3];
    {inv_clk, sov, bov, suv, buv} = v[4][4:0];
    {otg, otf} = v[5][4:0];
  endtask : apply

  // burst from 0x0D runs one past the bank into an unmapped offset
  task automatic run_check();
    apply();
    host_u.read_burst(8'h0D, 7);
    check({7'h00, host_u.acks}, 8'h01);
    for (int j = 0; j < 6; j++) begin
      check(host_u.rx[j], v[j] & msk[j]);
    end
    check(host_u.rx[6], 8'h00);
  endtask : run_check

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    rst = 1'b1;
    v = '{8'h00, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00};
    apply();
    repeat (16) @(posedge clk);
    #1;
    check({7'h00, sda_oe}, 8'h00);
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    run_check();
    // every flag position, set and clear
    for (int i = 0; i < 11; i++) begin
      for (int j = 0; j < 6; j++) begin
        v[j] = pat[(i + j) % 11];
      end
      run_check();
    end
    host_u.write_two(8'h0F, 8'h00, 8'hFF);
    check({7'h00, host_u.acks}, 8'h01);
    host_u.acks = 1'b1;
    host_u.read_cur(1);
    check(host_u.rx[0], v[4] & 8'h1F);
    run_check();
    // foreign address must not be acknowledged
    host_u.probe(7'h11);
    check({7'h00, host_u.acks}, 8'h00);
    run_check();
    finish_test();
  end
endmodule : amp_diag_fault_status_bank_test
